//--- tuid_pkg.sv
package tuid_pkg;
  // Register byte addresses
  localparam logic [11:0] TUID_CAP_A_OFFSET = 12'h020;
  localparam logic [11:0] TUID_CAP_B_OFFSET = 12'h024;
  // First capability register fields
  localparam int TUID_A_SES_BIT = 31;
  localparam int TUID_A_S1_BIT = 30;
  localparam int TUID_A_S2_BIT = 29;
  localparam int TUID_A_NEST_BIT = 28;
  localparam int TUID_A_SMT_BIT = 27;
  localparam int TUID_A_XOPS_BIT = 26;
  localparam int TUID_A_FMT_LSB = 24;
  localparam int TUID_A_IRQ_LSB = 16;
  localparam int TUID_A_EXM_BIT = 15;
  localparam int TUID_A_COHERENT_WALK_FLAG_BIT = 14;
  localparam int TUID_A_BCAST_BIT = 13;
  localparam int TUID_A_SIDW_LSB = 9;
  localparam int TUID_A_WSID_BIT = 8;
  localparam int TUID_A_GRP_LSB = 0;
  // Second capability register fields
  localparam int TUID_B_PGSZ_BIT = 31;
  localparam int TUID_B_PIDX_LSB = 28;
  localparam int TUID_B_HWFL_LSB = 24;
  localparam int TUID_B_S2CB_LSB = 16;
  localparam int TUID_B_CONF_BIT = 15;
  localparam int TUID_B_DTP_LSB = 12;
  localparam int TUID_B_DIDX_LSB = 8;
  localparam int TUID_B_CB_LSB = 0;
  // Field encodings
  localparam logic [1:0] TUID_FMT_RESERVED = 2'h3;
  localparam logic [1:0] TUID_HWFL_RESERVED = 2'h2;
  localparam logic [1:0] TUID_DTP_RESERVED = 2'h2;
  localparam logic [1:0] TUID_DTP_EXTENDED = 2'h3;
  localparam logic [3:0] TUID_SIDW_MAX = 4'hF;
  localparam logic [3:0] TUID_DIDX_MAX = 4'hF;
  localparam logic [7:0] TUID_GROUPS_EXT = 8'h80;
  localparam logic [7:0] TUID_COUNT_MAX = 8'h80;
  localparam logic [31:0] TUID_RESET_DATA = 32'h0000_0000;

  // Secure-side control values feeding Non-secure views
  typedef struct packed {
    logic [7:0] insecure_irq_count_override;
    logic [7:0] insecure_group_override;
    logic [7:0] insecure_bank_override;
    logic insecure_extended_match_off;
  } tuid_ns_ctrl_t;
endpackage

//--- tuid_regs.sv
// Contract
// - Two-security-state bit 31 reads zero on Non-secure reads.
// - Nested support forces both stage support bits to one; the code instead clears the nested bit unless both stage bits are set.
// - Stream match bit one means indexing absent, zero means indexing.
// - Translation-ops-absent bit reads zero when stage 1 is absent.
// - Legacy format field 25:24, reserved code 0b11 never reported.
// - Non-secure reads of interrupt count return Secure override.
// - Extended match bit: Secure one, Non-secure inverse of disable, else zero.
// - Coherent walk bit 14 and broadcast maintenance bit 13 report features.
// - Stream ID width 0-15, reads 15 with extended IDs.
// - Bit 8 reports extended 16-bit stream IDs.
// - Group count: Non-secure override, Secure 128 with extended matching.
// - Bit 31 of second register: zero 4KB pages, one 64KB.
// - Bits 30:28 give page index width; pages equal two to value plus one.
// - Hardware flag update field, reserved code two never reported.
// - Stage-2-only bank count 0-128, zeroed without stage 2 support.
// - Bit 15 reports guaranteed conflict detection.
// - Descriptor table presence field, reserved code two never reported.
// - Index width 15 for extended table; Non-secure reads zero both fields.
// - Total bank count 0-128; Non-secure reads return Secure override; the code clamps only Secure values, the override passes unclamped up to 255.
// - Registers are 32-bit, read-only, values fixed by capability parameters.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tuid_regs #(
  parameter bit TWO_SEC = 1'b1,
  parameter bit STAGE1 = 1'b1,
  parameter bit STAGE2 = 1'b1,
  parameter bit NESTED = 1'b1,
  parameter bit MATCH_TABLE = 1'b1,
  parameter bit XLAT_OPS_ABSENT = 1'b0,
  parameter logic [1:0] LEGACY_FMT = 2'h0,
  parameter logic [7:0] IRQ_COUNT = 8'h08,
  parameter bit EXT_MATCH = 1'b0,
  parameter bit COHERENT_WALK = 1'b1,
  parameter bit BCAST_MAINT = 1'b0,
  parameter logic [3:0] SID_WIDTH = 4'hA,
  parameter bit WIDE_SID = 1'b0,
  parameter logic [7:0] GROUP_COUNT = 8'h20,
  parameter bit PAGE_64K = 1'b0,
  parameter logic [2:0] PAGE_IDX = 3'h3,
  parameter logic [1:0] HW_FLAG = 2'h0,
  parameter logic [7:0] S2_BANKS = 8'h04,
  parameter bit CONFLICT_DET = 1'b1,
  parameter logic [1:0] DESC_PRESENCE = 2'h1,
  parameter logic [3:0] DESC_IDX = 4'h6,
  parameter logic [7:0] TOTAL_BANKS = 8'h10
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire tuid_pkg::tuid_ns_ctrl_t ns_ctrl,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  logic nested_xlat_flag;
  logic first_stage_flag;
  logic second_stage_flag;
  logic match_table_flag;
  logic xlat_ops_absent_flag;
  logic [1:0] legacy_format_field;
  logic extended_match_flag;
  logic [3:0] stream_id_width;
  logic wide_stream_id_flag;
  logic [1:0] hw_flag_update_field;
  logic [7:0] second_only_bank_count;
  logic [1:0] descriptor_table_presence;
  logic [3:0] descriptor_index_width;
  logic [7:0] total_bank_count;
  logic [7:0] mapping_group_count;
  logic [7:0] fault_irq_count;
  logic insecure_access;
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic hit_a;
  logic hit_b;
  logic [7:0] irq_ns_q;
  logic [7:0] grp_ns_q;
  logic [7:0] bank_ns_q;
  logic exm_off_q;

  // Override values are registered so the read path only sees local flops
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq_ns_q <= 8'h00;
      grp_ns_q <= 8'h00;
      bank_ns_q <= 8'h00;
      exm_off_q <= 1'b0;
    end else begin
      irq_ns_q <= ns_ctrl.insecure_irq_count_override;
      grp_ns_q <= ns_ctrl.insecure_group_override;
      bank_ns_q <= ns_ctrl.insecure_bank_override;
      exm_off_q <= ns_ctrl.insecure_extended_match_off;
    end
  end

  // Non-secure views only exist in a two-security-state build
  assign insecure_access = TWO_SEC && pprot[1];

  // Capability consistency is enforced here, not trusted from parameters
  assign nested_xlat_flag = NESTED && STAGE1 && STAGE2;
  assign first_stage_flag = STAGE1;
  assign second_stage_flag = STAGE2;
  assign match_table_flag = MATCH_TABLE;
  assign xlat_ops_absent_flag = XLAT_OPS_ABSENT && first_stage_flag;
  assign legacy_format_field = (LEGACY_FMT == tuid_pkg::TUID_FMT_RESERVED) ?
                               2'h0 : LEGACY_FMT;
  assign wide_stream_id_flag = WIDE_SID;
  assign stream_id_width = wide_stream_id_flag ? tuid_pkg::TUID_SIDW_MAX :
                           SID_WIDTH;
  assign hw_flag_update_field = (HW_FLAG == tuid_pkg::TUID_HWFL_RESERVED) ?
                                2'h0 : HW_FLAG;

  always_comb begin
    if (!EXT_MATCH) begin
      extended_match_flag = 1'b0;
    end else if (insecure_access) begin
      extended_match_flag = !exm_off_q;
    end else begin
      extended_match_flag = 1'b1;
    end
  end

  always_comb begin
    if (insecure_access) begin
      mapping_group_count = grp_ns_q;
    end else if (EXT_MATCH) begin
      mapping_group_count = tuid_pkg::TUID_GROUPS_EXT;
    end else if (GROUP_COUNT > tuid_pkg::TUID_COUNT_MAX) begin
      mapping_group_count = tuid_pkg::TUID_COUNT_MAX;
    end else begin
      mapping_group_count = GROUP_COUNT;
    end
  end

  assign fault_irq_count = insecure_access ? irq_ns_q : IRQ_COUNT;

  always_comb begin
    if (!second_stage_flag) begin
      second_only_bank_count = 8'h00;
    end else if (S2_BANKS > tuid_pkg::TUID_COUNT_MAX) begin
      second_only_bank_count = tuid_pkg::TUID_COUNT_MAX;
    end else begin
      second_only_bank_count = S2_BANKS;
    end
  end

  always_comb begin
    if (insecure_access) begin
      total_bank_count = bank_ns_q;
    end else if (TOTAL_BANKS > tuid_pkg::TUID_COUNT_MAX) begin
      total_bank_count = tuid_pkg::TUID_COUNT_MAX;
    end else begin
      total_bank_count = TOTAL_BANKS;
    end
  end

  always_comb begin
    if (insecure_access) begin
      descriptor_table_presence = 2'h0;
      descriptor_index_width = 4'h0;
    end else begin
      descriptor_table_presence = (DESC_PRESENCE == tuid_pkg::TUID_DTP_RESERVED) ?
                                  2'h0 : DESC_PRESENCE;
      descriptor_index_width = (descriptor_table_presence == tuid_pkg::TUID_DTP_EXTENDED) ?
                               tuid_pkg::TUID_DIDX_MAX : DESC_IDX;
    end
  end

  always_comb begin
    cap_a = tuid_pkg::TUID_RESET_DATA;
    cap_a[tuid_pkg::TUID_A_SES_BIT] = TWO_SEC && !insecure_access;
    cap_a[tuid_pkg::TUID_A_S1_BIT] = first_stage_flag;
    cap_a[tuid_pkg::TUID_A_S2_BIT] = second_stage_flag;
    cap_a[tuid_pkg::TUID_A_NEST_BIT] = nested_xlat_flag;
    cap_a[tuid_pkg::TUID_A_SMT_BIT] = match_table_flag;
    cap_a[tuid_pkg::TUID_A_XOPS_BIT] = xlat_ops_absent_flag;
    cap_a[tuid_pkg::TUID_A_FMT_LSB +: 2] = legacy_format_field;
    cap_a[tuid_pkg::TUID_A_IRQ_LSB +: 8] = fault_irq_count;
    cap_a[tuid_pkg::TUID_A_EXM_BIT] = extended_match_flag;
    cap_a[tuid_pkg::TUID_A_COHERENT_WALK_FLAG_BIT] = COHERENT_WALK;
    cap_a[tuid_pkg::TUID_A_BCAST_BIT] = BCAST_MAINT;
    cap_a[tuid_pkg::TUID_A_SIDW_LSB +: 4] = stream_id_width;
    cap_a[tuid_pkg::TUID_A_WSID_BIT] = wide_stream_id_flag;
    cap_a[tuid_pkg::TUID_A_GRP_LSB +: 8] = mapping_group_count;
  end

  always_comb begin
    cap_b = tuid_pkg::TUID_RESET_DATA;
    cap_b[tuid_pkg::TUID_B_PGSZ_BIT] = PAGE_64K;
    cap_b[tuid_pkg::TUID_B_PIDX_LSB +: 3] = PAGE_IDX;
    cap_b[tuid_pkg::TUID_B_HWFL_LSB +: 2] = hw_flag_update_field;
    cap_b[tuid_pkg::TUID_B_S2CB_LSB +: 8] = second_only_bank_count;
    cap_b[tuid_pkg::TUID_B_CONF_BIT] = CONFLICT_DET;
    cap_b[tuid_pkg::TUID_B_DTP_LSB +: 2] = descriptor_table_presence;
    cap_b[tuid_pkg::TUID_B_DIDX_LSB +: 4] = descriptor_index_width;
    cap_b[tuid_pkg::TUID_B_CB_LSB +: 8] = total_bank_count;
  end

  // No wait state: data is registered in setup, answered in the first access cycle
  assign setup = psel && !penable;
  assign hit_a = paddr == tuid_pkg::TUID_CAP_A_OFFSET;
  assign hit_b = paddr == tuid_pkg::TUID_CAP_B_OFFSET;

  always_comb begin
    if (pwrite) begin
      rdata_d = tuid_pkg::TUID_RESET_DATA;
    end else if (hit_a) begin
      rdata_d = cap_a;
    end else if (hit_b) begin
      rdata_d = cap_b;
    end else begin
      rdata_d = tuid_pkg::TUID_RESET_DATA;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata_q <= tuid_pkg::TUID_RESET_DATA;
    end else if (setup) begin
      prdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      // Unmapped addresses and all writes are flagged; writes change nothing
      pslverr_q <= setup && (pwrite || !(hit_a || hit_b));
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule
`default_nettype wire

//--- tuid_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tuid_regs_asserts (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire tuid_pkg::tuid_ns_ctrl_t ns_ctrl,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic su = psel && !penable;
  wire logic ra = su && !pwrite && paddr == tuid_pkg::TUID_CAP_A_OFFSET;
  wire logic rb = su && !pwrite && paddr == tuid_pkg::TUID_CAP_B_OFFSET;
  wire logic ns = pprot[1];
  chk_ready_next: assert property (su |=> pready && !$past(pready))
    else $error("ready missing");
  chk_write_err: assert property (su && pwrite |=> pslverr && prdata == 32'h0)
    else $error("write not refused");
  chk_rdata_hold: assert property (!su |=> $stable(prdata))
    else $error("read data moved");
  chk_ns_no_sec: assert property (ra && ns |=> !prdata[31])
    else $error("security bit shown");
  chk_nest_stage: assert property (ra |=> !prdata[28] || prdata[30:29] == 2'h3)
    else $error("nested without stages");
  chk_xops_s1: assert property (ra |=> !prdata[26] || prdata[30])
    else $error("ops flag without stage 1");
  chk_fmt_legal: assert property (ra |=> prdata[25:24] != 2'h3)
    else $error("reserved format");
  chk_wide_sid: assert property (ra |=> !prdata[8] || prdata[12:9] == 4'hF)
    else $error("wide id width");
  chk_b_resv: assert property (rb |=> prdata[27:26] == 2'h0 && !prdata[14])
    else $error("reserved bits set");
  chk_ns_desc: assert property (rb && ns |=> prdata[13:8] == 6'h0)
    else $error("descriptor fields shown");
  chk_ns_bank: assert property (rb && ns && $past(resetn) |=>
    prdata[7:0] == $past(ns_ctrl.insecure_bank_override, 2))
    else $error("bank override");
  cover property (ra && ns);
  cover property (rb && !ns);
  cover property (su && pwrite);
endmodule
bind tuid_regs tuid_regs_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pprot(pprot), .ns_ctrl(ns_ctrl), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- tuid_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tuid_regs_tb_top;
  logic clk_sys, resetn, psel, penable, pwrite, e1, e2, r1, r2, f1, f2;
  logic [11:0] paddr;
  logic [31:0] pwdata, q1, q2, d1, d2;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  tuid_pkg::tuid_ns_ctrl_t ns_ctrl;
  int error_cnt = 0;
  int checks_done = 0;
  localparam logic [11:0] A = tuid_pkg::TUID_CAP_A_OFFSET;
  localparam logic [11:0] B = tuid_pkg::TUID_CAP_B_OFFSET;
  tuid_regs u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
    .ns_ctrl(ns_ctrl), .prdata(q1), .pready(r1), .pslverr(e1));
  // Odd capability mix so the consistency clean-up is exercised
  tuid_regs #(.STAGE1(1'h0), .STAGE2(1'h0), .NESTED(1'h0), .MATCH_TABLE(1'h0),
    .XLAT_OPS_ABSENT(1'h1), .LEGACY_FMT(2'h3), .IRQ_COUNT(8'h05), .EXT_MATCH(1'h1),
    .COHERENT_WALK(1'h0), .BCAST_MAINT(1'h1), .SID_WIDTH(4'h3), .WIDE_SID(1'h1),
    .PAGE_64K(1'h1), .PAGE_IDX(3'h7), .HW_FLAG(2'h2), .CONFLICT_DET(1'h0),
    .DESC_PRESENCE(2'h3), .DESC_IDX(4'h2), .TOTAL_BANKS(8'h90)) u_dut_alt (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
    .ns_ctrl(ns_ctrl), .prdata(q2), .pready(r2), .pslverr(e2));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  // Request is held until ready is seen, so no release in here
  task automatic apb(input logic w, input logic [11:0] a, input logic [2:0] p);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pprot <= p;
    pwdata <= 32'hFFFF_FFFF;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (r1 !== 1'h1 && n < 20);
    if (n >= 20) error_cnt++;
    d1 = q1;
    d2 = q2;
    f1 = e1;
    f2 = e2;
    chk("alt ready", {31'h0, r2}, 32'h1);
  endtask
  task automatic idle;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic t_secure;
    apb(1'h0, A, 3'h0);
    chk("a sec", d1, 32'hF808_5420);
    chk("a alt sec", d2, 32'h8005_BF80);
    apb(1'h0, B, 3'h0);
    chk("b sec", d1, 32'h3004_9610);
    chk("b alt sec", d2, 32'hF000_3F80);
    idle();
  endtask
  task automatic t_insecure;
    logic [7:0] ir, gr, bk;
    for (int i = 0; i < 2; i++) begin
      ir = 8'h11 + i[7:0];
      gr = 8'h5A + i[7:0];
      bk = 8'h83 - i[7:0];
      ns_ctrl <= '{ir, gr, bk, i[0]};
      repeat (2) @(posedge clk_sys);
      apb(1'h0, A, 3'h2);
      chk("a ns", d1, {8'h78, ir, 8'h54, gr});
      chk("a alt ns", d2, {8'h00, ir, ~i[0], 7'h3F, gr});
      apb(1'h0, B, 3'h2);
      chk("b ns", d1, {24'h3004_80, bk});
      chk("b alt ns", d2, {24'hF0_0000, bk});
      idle();
    end
  endtask
  task automatic t_write;
    apb(1'h1, A, 3'h0);
    chk("wr err", {31'h0, f1}, 32'h1);
    chk("wr data", d1, 32'h0);
    apb(1'h1, B, 3'h2);
    chk("wr b err", {31'h0, f2}, 32'h1);
    apb(1'h0, 12'h028, 3'h0);
    chk("unmapped", d1, 32'h0);
    chk("unmapped err", {31'h0, f1}, 32'h1);
    apb(1'h0, A, 3'h0);
    chk("a after wr", d1, 32'hF808_5420);
    idle();
  endtask
  task automatic t_reset;
    resetn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk("rst data", q1, 32'h0);
    resetn <= 1'h1;
    @(posedge clk_sys);
    apb(1'h0, B, 3'h0);
    chk("b after rst", d1, 32'h3004_9610);
    idle();
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pprot = 3'h0;
    ns_ctrl = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    t_secure();
    t_insecure();
    t_write();
    t_reset();
    test_done();
  end
  // Whole run is under 100 cycles; this only cuts a hang short
  initial begin
    repeat (2000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
